// ==== csc_config_regs.sv ====
// Serial configuration register bank with watchdog of the clock synthesizer
`default_nettype none
module csc_config_regs #(
    parameter int SHORT_CYC = csc_pkg::WD_SHORT_CYC,
    parameter int LONG_CYC  = csc_pkg::WD_LONG_CYC,
    parameter int PULSE_CYC = csc_pkg::RST_PULSE_CYC
) (
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic       frame_start,
    input  wire logic       frame_stop,
    input  wire logic       bit_valid,
    input  wire logic       bit_in,
    input  wire logic       bit_rd_req,
    output logic            bit_out,
    input  wire logic [4:0] strap_freq_code,
    output logic            freq_source_choice,
    output logic [4:0]      active_freq_code,
    output logic            freq_change,
    output logic [2:0]      spread_mode,
    output logic            outputs_tristated,
    output logic            spread_test_mode,
    output logic [2:0]      host_clk_on,
    output logic [2:0]      intc_clk_on,
    output logic [8:0]      pci_clk_on,
    output logic [2:0]      gfx_clk_on,
    output logic            usb_clk_on,
    output logic            sio_clk_on,
    output logic [1:0]      refout_on,
    output logic            sio_clk_rate_choice,
    output logic [1:0]      periph_skew,
    output logic            usb_clk_drive,
    output logic            sio_clk_drive,
    output logic            wdog_expired_flag,
    output logic            sys_reset_pulse
);
    localparam int PW = $clog2(PULSE_CYC + 1);

    csc_pkg::csc_state_e state_ff, nxt_state;
    logic [7:0]  cfg_ff [0:csc_pkg::NUM_RW_BYTES-1];
    logic [7:0]  nxt_cfg [0:csc_pkg::NUM_RW_BYTES-1];
    logic [6:0]  ofs_ff, nxt_ofs;
    logic [2:0]  bcnt_ff, nxt_bcnt;
    logic [7:0]  shin_ff, nxt_shin;
    logic [2:0]  rcnt_ff, nxt_rcnt;
    logic [7:0]  shout_ff, nxt_shout;
    logic        bout_ff, nxt_bout;
    logic        rst_en_ff, nxt_rst_en;
    logic        run_ff, nxt_run;
    logic        flag_ff, nxt_flag;
    logic        lock_ff, nxt_lock;
    logic        counting_ff, nxt_counting;
    logic [4:0]  wcnt_ff, nxt_wcnt;
    logic [PW-1:0] pcnt_ff, nxt_pcnt;
    logic        srst_ff, nxt_srst;
    logic [4:0]  code_ff, nxt_code;
    logic        fchg_ff, nxt_fchg;
    logic [4:0]  strap_q_ff;
    logic [7:0]  wr_byte;
    logic        wr_now;
    logic        expire;
    logic        restart;
    logic        tick;
    logic [4:0]  reg_code;
    logic        outs_tri_ff, nxt_tri;
    logic        test_ff, nxt_test;

    // Current content of any byte; unmapped offsets read as zero
    function automatic logic [7:0] rd_byte(input logic [6:0] ofs,
                                           input logic [7:0] b0,
                                           input logic [7:0] b1,
                                           input logic [7:0] b2,
                                           input logic [7:0] b3,
                                           input logic [7:0] b4,
                                           input logic [7:0] b5,
                                           input logic [7:0] wd);
        case (ofs)
            csc_pkg::OFS_FREQ:      rd_byte = b0;
            csc_pkg::OFS_SPREAD:    rd_byte = b1;
            csc_pkg::OFS_PERIPH:    rd_byte = b2;
            csc_pkg::OFS_MISC:      rd_byte = b3;
            csc_pkg::OFS_WDOG:      rd_byte = b4;
            csc_pkg::OFS_DRIVE:     rd_byte = b5;
            csc_pkg::OFS_RSVD6:     rd_byte = csc_pkg::RST_RSVD;
            csc_pkg::OFS_RSVD7:     rd_byte = csc_pkg::RST_RSVD;
            csc_pkg::OFS_WDOG_CTRL: rd_byte = wd;
            default:                rd_byte = csc_pkg::RST_ZERO;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Serial framing: command byte, then data bytes, each MSB first
    always_comb
    begin
        nxt_state = state_ff;
        nxt_ofs   = ofs_ff;
        nxt_bcnt  = bcnt_ff;
        nxt_shin  = shin_ff;
        nxt_rcnt  = rcnt_ff;
        nxt_shout = shout_ff;
        nxt_bout  = bout_ff;
        wr_byte   = {shin_ff[6:0], bit_in};
        wr_now    = 1'b0;
        case (state_ff)
            csc_pkg::CSC_IDLE:
            begin
                nxt_bcnt = 3'h0;
            end
            csc_pkg::CSC_CMD:
            begin
                if (bit_valid)
                begin
                    nxt_shin = wr_byte;
                    nxt_bcnt = bcnt_ff + 3'h1;
                    if (bcnt_ff == 3'h7)
                    begin
                        // Byte access lands at the offset, block at zero
                        nxt_ofs = wr_byte[csc_pkg::CMD_BYTE_MODE_BIT]
                                ? wr_byte[6:0] : csc_pkg::OFS_FREQ;
                        nxt_rcnt  = 3'h0;
                        nxt_state = csc_pkg::CSC_DATA;
                    end
                end
            end
            csc_pkg::CSC_DATA:
            begin
                if (bit_valid)
                begin
                    nxt_shin = wr_byte;
                    nxt_bcnt = bcnt_ff + 3'h1;
                    if (bcnt_ff == 3'h7)
                    begin
                        wr_now  = 1'b1;
                        nxt_ofs = ofs_ff + 7'h01;
                    end
                end
                else if (bit_rd_req)
                begin
                    // Snapshot at the first bit so a byte never tears
                    if (rcnt_ff == 3'h0)
                    begin
                        nxt_shout = rd_byte(ofs_ff, cfg_ff[0], cfg_ff[1],
                            cfg_ff[2], cfg_ff[3], cfg_ff[4], cfg_ff[5],
                            {3'h0, rst_en_ff, 1'b0, flag_ff, run_ff, 1'b0});
                    end
                    else
                    begin
                        nxt_shout = {shout_ff[6:0], 1'b0};
                    end
                    nxt_bout = (rcnt_ff == 3'h0)
                             ? nxt_shout[7] : shout_ff[6];
                    nxt_rcnt = rcnt_ff + 3'h1;
                    if (rcnt_ff == 3'h7)
                    begin
                        nxt_ofs = ofs_ff + 7'h01;
                    end
                end
            end
            default:
            begin
                nxt_state = csc_pkg::CSC_IDLE;
            end
        endcase
        // A stop drops any partial byte; a start wins over it
        if (frame_stop)
        begin
            nxt_state = csc_pkg::CSC_IDLE;
        end
        if (frame_start)
        begin
            nxt_state = csc_pkg::CSC_CMD;
            nxt_bcnt  = 3'h0;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_ff <= csc_pkg::CSC_IDLE;
            ofs_ff   <= 7'h00;
            bcnt_ff  <= 3'h0;
            shin_ff  <= 8'h00;
            rcnt_ff  <= 3'h0;
            shout_ff <= 8'h00;
            bout_ff  <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            ofs_ff   <= nxt_ofs;
            bcnt_ff  <= nxt_bcnt;
            shin_ff  <= nxt_shin;
            rcnt_ff  <= nxt_rcnt;
            shout_ff <= nxt_shout;
            bout_ff  <= nxt_bout;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register bytes and watchdog control; reserved bits of bytes 0 to 5 kept as written, those of the control byte read as zero
    always_comb
    begin
        for (int i = 0; i < csc_pkg::NUM_RW_BYTES; i++)
        begin
            nxt_cfg[i] = cfg_ff[i];
        end
        nxt_rst_en = rst_en_ff;
        nxt_run    = run_ff;
        nxt_flag   = flag_ff;
        nxt_fchg   = 1'b0;
        if (wr_now)
        begin
            if (ofs_ff < 7'(csc_pkg::NUM_RW_BYTES))
            begin
                // Recovery lock refuses frequency changes
                if (!(lock_ff && ofs_ff == csc_pkg::OFS_FREQ))
                begin
                    nxt_cfg[ofs_ff[2:0]] = wr_byte;
                end
                if (!lock_ff && ofs_ff == csc_pkg::OFS_FREQ
                    && wr_byte != cfg_ff[0])
                begin
                    nxt_fchg = 1'b1;
                end
            end
            else if (ofs_ff == csc_pkg::OFS_WDOG_CTRL)
            begin
                nxt_rst_en = wr_byte[csc_pkg::WD_RST_EN_BIT];
                nxt_run    = wr_byte[csc_pkg::WD_RUN_BIT];
                if (wr_byte[csc_pkg::WD_FLAG_BIT])
                begin
                    nxt_flag = 1'b0;
                end
            end
        end
        // Strap moves count as a change while byte 0 selects the straps, not in recovery mode alone
        if (!cfg_ff[0][csc_pkg::FREQ_SRC_BIT] && strap_q_ff != strap_freq_code)
        begin
            nxt_fchg = 1'b1;
        end
        if (expire)
        begin
            nxt_flag = 1'b1;                      // Set wins
        end
        // Spread decode registered so the pins never glitch
        nxt_tri  = nxt_cfg[1][csc_pkg::SPREAD_HI:csc_pkg::SPREAD_LO]
                 == csc_pkg::SPREAD_TRI;
        nxt_test = nxt_cfg[1][csc_pkg::SPREAD_HI:csc_pkg::SPREAD_LO]
                 == csc_pkg::SPREAD_TEST;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < csc_pkg::NUM_RW_BYTES; i++)
            begin
                cfg_ff[i] <= csc_pkg::RST_BYTES[i*8 +: 8];
            end
            rst_en_ff  <= 1'b0;
            run_ff     <= 1'b0;
            flag_ff    <= 1'b0;
            fchg_ff    <= 1'b0;
            strap_q_ff <= 5'h00;
            outs_tri_ff <= 1'b0;
            test_ff     <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < csc_pkg::NUM_RW_BYTES; i++)
            begin
                cfg_ff[i] <= nxt_cfg[i];
            end
            rst_en_ff  <= nxt_rst_en;
            run_ff     <= nxt_run;
            flag_ff    <= nxt_flag;
            fchg_ff    <= nxt_fchg;
            strap_q_ff <= strap_freq_code;
            outs_tri_ff <= nxt_tri;
            test_ff     <= nxt_test;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Watchdog: armed by run, started by a frequency change
    assign restart = nxt_fchg && run_ff && !counting_ff;
    assign expire  = counting_ff && tick && wcnt_ff <= 5'h01;

    csc_wdog_tick #(
        .SHORT_CYC (SHORT_CYC),
        .LONG_CYC  (LONG_CYC)
    ) csc_wdog_tick_i (
        .mclk       (mclk),
        .rstn       (rstn),
        .enable     (counting_ff),
        .restart    (restart),
        .long_scale (cfg_ff[4][csc_pkg::PRESCALE_BIT]),
        .tick       (tick)
    );

    always_comb
    begin
        nxt_counting = counting_ff;
        nxt_wcnt     = wcnt_ff;
        nxt_lock     = lock_ff;
        nxt_pcnt     = pcnt_ff;
        nxt_srst     = pcnt_ff != '0;
        if (pcnt_ff != '0)
        begin
            nxt_pcnt = pcnt_ff - PW'(1);
        end
        if (!run_ff)
        begin
            // Stopped: hold the reload value and leave recovery mode
            nxt_counting = 1'b0;
            nxt_wcnt     = cfg_ff[4][csc_pkg::RELOAD_HI:0];
            nxt_lock     = 1'b0;
        end
        else if (restart)
        begin
            nxt_counting = 1'b1;
            nxt_wcnt     = cfg_ff[4][csc_pkg::RELOAD_HI:0];
        end
        else if (expire)
        begin
            nxt_counting = 1'b0;
            nxt_lock     = 1'b1;
            if (rst_en_ff)
            begin
                nxt_pcnt = PW'(PULSE_CYC);
            end
        end
        else if (counting_ff && tick)
        begin
            nxt_wcnt = wcnt_ff - 5'h01;
        end
        // Recovery mode follows the straps regardless of byte 0
        reg_code = {cfg_ff[0][csc_pkg::SEL4_BIT], cfg_ff[0][csc_pkg::SEL3_BIT],
                    cfg_ff[0][csc_pkg::SEL_LO_HI:csc_pkg::SEL_LO_LO]};
        nxt_code = (cfg_ff[0][csc_pkg::FREQ_SRC_BIT] && !nxt_lock)
                 ? reg_code : strap_freq_code;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            counting_ff <= 1'b0;
            wcnt_ff     <= 5'h00;
            lock_ff     <= 1'b0;
            pcnt_ff     <= '0;
            srst_ff     <= 1'b0;
            code_ff     <= 5'h00;
        end
        else
        begin
            counting_ff <= nxt_counting;
            wcnt_ff     <= nxt_wcnt;
            lock_ff     <= nxt_lock;
            pcnt_ff     <= nxt_pcnt;
            srst_ff     <= nxt_srst;
            code_ff     <= nxt_code;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs are bits of the register flops; frequency table lies outside
    assign bit_out             = bout_ff;
    assign freq_source_choice  = cfg_ff[0][csc_pkg::FREQ_SRC_BIT];
    assign active_freq_code    = code_ff;
    assign freq_change         = fchg_ff;
    assign spread_mode = cfg_ff[1][csc_pkg::SPREAD_HI:csc_pkg::SPREAD_LO];
    assign outputs_tristated   = outs_tri_ff;
    assign spread_test_mode    = test_ff;
    assign host_clk_on         = cfg_ff[1][3:1];
    assign intc_clk_on         = {cfg_ff[1][0], cfg_ff[5][5:4]};
    assign pci_clk_on = {cfg_ff[3][csc_pkg::PCIF_ON_BIT], cfg_ff[2]};
    assign gfx_clk_on          = cfg_ff[3][2:0];
    assign usb_clk_on          = cfg_ff[3][csc_pkg::USB_ON_BIT];
    assign sio_clk_on          = cfg_ff[3][csc_pkg::SIO_ON_BIT];
    assign refout_on           = cfg_ff[5][1:0];
    assign sio_clk_rate_choice = cfg_ff[3][csc_pkg::SIO_RATE_BIT];
    assign periph_skew = cfg_ff[4][csc_pkg::SKEW_HI:csc_pkg::SKEW_LO];
    assign usb_clk_drive       = cfg_ff[5][csc_pkg::USB_DRV_BIT];
    assign sio_clk_drive       = cfg_ff[5][csc_pkg::SIO_DRV_BIT];
    assign wdog_expired_flag   = flag_ff;
    assign sys_reset_pulse     = srst_ff;
endmodule
`default_nettype wire

// ==== csc_config_regs_chk.sv ====
// Port assertions of the configuration register bank
`default_nettype none
module csc_config_regs_chk #(
    parameter int SHORT_CYC = 20,
    parameter int LONG_CYC  = 50,
    parameter int PULSE_CYC = 16
) (
    input wire logic       mclk,
    input wire logic       rstn,
    input wire logic       bit_valid,
    input wire logic       bit_rd_req,
    input wire logic       bit_out,
    input wire logic [4:0] strap_freq_code,
    input wire logic       freq_source_choice,
    input wire logic [4:0] active_freq_code,
    input wire logic [2:0] spread_mode,
    input wire logic       outputs_tristated,
    input wire logic       spread_test_mode,
    input wire logic [1:0] periph_skew,
    input wire logic       usb_clk_drive,
    input wire logic       wdog_expired_flag,
    input wire logic       sys_reset_pulse
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////////
    // Three settled cycles give the code pipeline time to catch up
    chk_strap_follow: assert property (
        (!freq_source_choice)[*3] |->
        active_freq_code == $past(strap_freq_code))
        else $error("active code does not follow straps");
    chk_tri_decode: assert property (
        $stable(spread_mode) |-> outputs_tristated == (spread_mode == 3'h3))
        else $error("three-state decode wrong");
    chk_test_decode: assert property (
        $stable(spread_mode) |-> spread_test_mode == (spread_mode == 3'h1))
        else $error("test mode decode wrong");
    chk_pulse_width: assert property (
        $rose(sys_reset_pulse) |-> sys_reset_pulse[*8] ##8 sys_reset_pulse
        ##1 !sys_reset_pulse)
        else $error("reset pulse width wrong");
    chk_pulse_cause: assert property (
        $rose(sys_reset_pulse) |-> wdog_expired_flag)
        else $error("reset pulse without expiry");
    chk_flag_clear: assert property (
        $fell(wdog_expired_flag) |-> $past(bit_valid))
        else $error("expired flag dropped without a write");
    chk_cfg_hold: assert property (
        $changed({spread_mode, periph_skew, usb_clk_drive}) |->
        $past(bit_valid))
        else $error("setting changed without a write");
    chk_read_hold: assert property (
        $changed(bit_out) |-> $past(bit_rd_req))
        else $error("read bit changed without request");
endmodule

bind csc_config_regs csc_config_regs_chk #(
    .SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC), .PULSE_CYC(PULSE_CYC)
) csc_config_regs_chk_i (
    .mclk(mclk), .rstn(rstn), .bit_valid(bit_valid),
    .bit_rd_req(bit_rd_req), .bit_out(bit_out),
    .strap_freq_code(strap_freq_code),
    .freq_source_choice(freq_source_choice),
    .active_freq_code(active_freq_code), .spread_mode(spread_mode),
    .outputs_tristated(outputs_tristated),
    .spread_test_mode(spread_test_mode), .periph_skew(periph_skew),
    .usb_clk_drive(usb_clk_drive), .wdog_expired_flag(wdog_expired_flag),
    .sys_reset_pulse(sys_reset_pulse)
);
`default_nettype wire

// ==== csc_config_regs_tb_top.sv ====
// Self-checking bench of the configuration register bank
`default_nettype none
module csc_config_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       mclk = 1'b0;
    logic       rstn = 1'b0;
    logic [4:0] strap_freq_code = 5'h11;
    int         n_errors = 0;
    int         checks = 0;
    int         cyc = 0;
    logic [7:0] v;
    wire logic  fstart, fp, bv, bi, rr, bit_out, freq_source_choice, fchg;
    wire logic  outputs_tristated, spread_test_mode, usb_clk_on, sio_clk_on;
    wire logic  sio_clk_rate_choice, usb_clk_drive, sio_clk_drive;
    wire logic  wdog_expired_flag, sys_reset_pulse;
    wire logic [4:0] active_freq_code;
    wire logic [2:0] spread_mode, host_clk_on, intc_clk_on, gfx_clk_on;
    wire logic [8:0] pci_clk_on;
    wire logic [1:0] refout_on, periph_skew;

    csc_config_regs #(.SHORT_CYC(20), .LONG_CYC(50)) csc_config_regs_i (
        .mclk(mclk), .rstn(rstn), .frame_start(fstart), .frame_stop(fp),
        .bit_valid(bv), .bit_in(bi), .bit_rd_req(rr), .bit_out(bit_out),
        .strap_freq_code(strap_freq_code),
        .freq_source_choice(freq_source_choice),
        .active_freq_code(active_freq_code), .freq_change(fchg),
        .spread_mode(spread_mode), .outputs_tristated(outputs_tristated),
        .spread_test_mode(spread_test_mode), .host_clk_on(host_clk_on),
        .intc_clk_on(intc_clk_on), .pci_clk_on(pci_clk_on),
        .gfx_clk_on(gfx_clk_on), .usb_clk_on(usb_clk_on),
        .sio_clk_on(sio_clk_on), .refout_on(refout_on),
        .sio_clk_rate_choice(sio_clk_rate_choice),
        .periph_skew(periph_skew), .usb_clk_drive(usb_clk_drive),
        .sio_clk_drive(sio_clk_drive),
        .wdog_expired_flag(wdog_expired_flag),
        .sys_reset_pulse(sys_reset_pulse));
    csc_host_model csc_host_model_i (
        .mclk(mclk), .bit_out(bit_out), .frame_start(fstart),
        .frame_stop(fp), .bit_valid(bv), .bit_in(bi), .bit_rd_req(rr));

    ////////////////////////////////////////////////////////////////////
    // Clock and a hang limit well above the expected run
    always #4 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            n_errors++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (n_errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Single-byte accesses; settle so outputs have landed
    task automatic wr(input logic [6:0] ofs, input logic [7:0] d);
        csc_host_model_i.open({1'b1, ofs});
        csc_host_model_i.put_byte(d);
        csc_host_model_i.close();
        repeat (2) @(posedge mclk);
        #1;
    endtask

    task automatic rd(input logic [6:0] ofs, output logic [7:0] d);
        csc_host_model_i.open({1'b1, ofs});
        csc_host_model_i.get_byte(d);
        csc_host_model_i.close();
    endtask

    // Block read of bytes 0 to 7 from zero, single read of byte 9, then outputs at reset
    task automatic t_reset();
        logic [7:0] rv [8] = '{8'h04, 8'h0f, 8'hff, 8'h3f,
                               8'h1f, 8'hf3, 8'hff, 8'hff};
        csc_host_model_i.open(8'h00);
        for (int i = 0; i < 8; i++)
        begin
            csc_host_model_i.get_byte(v);
            compare(v, rv[i]);
        end
        csc_host_model_i.close();
        rd(7'h09, v);
        compare(v, 8'h00);
        compare({pci_clk_on, usb_clk_on, sio_clk_on, host_clk_on, intc_clk_on,
                 gfx_clk_on, refout_on}, 22'h3fffff);
        compare({usb_clk_drive, sio_clk_drive}, 2'h3);
    endtask

    // Register code versus strap pins
    task automatic t_freq();
        wr(7'h00, 8'h6e);
        compare({freq_source_choice, active_freq_code}, 6'h3e);
        wr(7'h00, 8'h60);
        compare(active_freq_code, 5'h11);
        @(posedge mclk);
        strap_freq_code <= 5'h0a;
        @(posedge mclk);
        #1 compare({fchg, active_freq_code}, 6'h2a);
        @(posedge mclk);
        strap_freq_code <= 5'h11;
    endtask

    // Every spread code, then setting bytes 3 to 5
    task automatic t_settings();
        for (int m = 0; m < 8; m++)
        begin
            wr(7'h01, {1'b0, m[2:0], 4'hf});
            compare({spread_mode, outputs_tristated, spread_test_mode},
                    {m[2:0], m == 3, m == 1});
        end
        wr(7'h03, 8'h40);
        wr(7'h04, 8'hc0);
        wr(7'h05, 8'h00);
        compare({sio_clk_rate_choice, usb_clk_on, sio_clk_on, gfx_clk_on,
                 pci_clk_on[8]}, 7'h40);
        compare(periph_skew, 2'h3);
        compare({usb_clk_drive, sio_clk_drive, refout_on, intc_clk_on},
                7'h04);
        wr(7'h06, 8'h00);
        rd(7'h06, v);
        compare(v, 8'hff);
    endtask

    // Arm, change frequency, time the expiry, then clear
    task automatic t_wdog(input logic lng, input logic ren, input int n,
                          input logic [7:0] b0);
        int t;
        int p;
        int u;
        u = lng ? 50 : 20;
        t = 0;
        p = 0;
        wr(7'h04, {2'b00, lng, n[4:0]});
        wr(7'h09, {3'b000, ren, 4'h2});
        wr(7'h00, b0);
        while (wdog_expired_flag !== 1'b1 && t < 400)
        begin
            @(posedge mclk);
            #1 t++;
        end
        compare(t >= (n - 1) * u && t <= n * u + 8, 1'b1);
        repeat (30)
        begin
            @(posedge mclk);
            #1 p += sys_reset_pulse;
        end
        compare(p, ren ? 16 : 0);
        compare(active_freq_code, 5'h11);
        rd(7'h09, v);
        compare(v, {3'b000, ren, 4'h6});
        wr(7'h09, 8'h04);
        rd(7'h09, v);
        compare(v, 8'h00);
    endtask

    // Reset, then the scenarios in turn
    initial
    begin
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        t_reset();
        t_freq();
        t_settings();
        t_wdog(1'b0, 1'b1, 3, 8'h68);
        t_wdog(1'b1, 1'b0, 1, 8'h60);
        end_of_test();
    end
endmodule
`default_nettype wire

// ==== csc_host_model.sv ====
// Host controller model that drives the serial configuration port
`default_nettype none
module csc_host_model (
    input  wire logic mclk,
    input  wire logic bit_out,
    output var logic  frame_start,
    output var logic  frame_stop,
    output var logic  bit_valid,
    output var logic  bit_in,
    output var logic  bit_rd_req
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle lines at time zero
    initial
    begin
        {frame_start, frame_stop, bit_valid, bit_in, bit_rd_req} = 5'h00;
    end

    ////////////////////////////////////////////////////////////////////
    // Bits go most significant first, bytes in ascending order
    task automatic put_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
        begin
            @(posedge mclk);
            bit_valid <= 1'b1;
            bit_in    <= b[i];
        end
        @(posedge mclk);
        bit_valid <= 1'b0;
        bit_in    <= ~b[0]; // Released line never shows stale data
    endtask

    // Read bit is valid after the edge that takes the request
    task automatic get_byte(output logic [7:0] b);
        for (int i = 7; i >= 0; i--)
        begin
            @(posedge mclk);
            bit_rd_req <= 1'b1;
            @(posedge mclk);
            bit_rd_req <= 1'b0;
            #1 b[i] = bit_out;
        end
    endtask

    // Frame opens with the command code: top bit set for one byte
    task automatic open(input logic [7:0] cmd);
        @(posedge mclk);
        frame_start <= 1'b1;
        @(posedge mclk);
        frame_start <= 1'b0;
        put_byte(cmd);
    endtask

    task automatic close();
        @(posedge mclk);
        frame_stop <= 1'b1;
        @(posedge mclk);
        frame_stop <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== csc_pkg.sv ====
// Constants shared by the clock synthesizer configuration register bank
`default_nettype none
package csc_pkg;
    // Byte offsets reached by the command code
    localparam logic [6:0] OFS_FREQ      = 7'h00;
    localparam logic [6:0] OFS_SPREAD    = 7'h01;
    localparam logic [6:0] OFS_PERIPH    = 7'h02;
    localparam logic [6:0] OFS_MISC      = 7'h03;
    localparam logic [6:0] OFS_WDOG      = 7'h04;
    localparam logic [6:0] OFS_DRIVE     = 7'h05;
    localparam logic [6:0] OFS_RSVD6     = 7'h06;
    localparam logic [6:0] OFS_RSVD7     = 7'h07;
    localparam logic [6:0] OFS_WDOG_CTRL = 7'h09;
    localparam int         NUM_RW_BYTES  = 6;

    // Reset values of bytes 5..0, byte 0 in the low lane
    localparam logic [47:0] RST_BYTES   = 48'hf3_1f_3f_ff_0f_04;
    localparam logic [7:0]  RST_RSVD    = 8'hff;
    localparam logic [7:0]  RST_ZERO    = 8'h00;

    // Command code layout
    localparam int CMD_BYTE_MODE_BIT = 7;

    // Byte 0 fields
    localparam int FREQ_SRC_BIT = 3;
    localparam int SEL_LO_HI    = 6;
    localparam int SEL_LO_LO    = 4;
    localparam int SEL4_BIT     = 2;
    localparam int SEL3_BIT     = 1;
    // Byte 1 fields
    localparam int SPREAD_HI    = 6;
    localparam int SPREAD_LO    = 4;
    localparam logic [2:0] SPREAD_TEST = 3'h1;
    localparam logic [2:0] SPREAD_TRI  = 3'h3;
    // Byte 3 fields
    localparam int SIO_RATE_BIT = 6;
    localparam int USB_ON_BIT   = 5;
    localparam int SIO_ON_BIT   = 4;
    localparam int PCIF_ON_BIT  = 3;
    // Byte 4 fields
    localparam int SKEW_HI      = 7;
    localparam int SKEW_LO      = 6;
    localparam int RELOAD_HI    = 4;
    localparam int PRESCALE_BIT = 5;
    // Byte 5 fields
    localparam int USB_DRV_BIT  = 7;
    localparam int SIO_DRV_BIT  = 6;
    // Watchdog control byte fields
    localparam int WD_RST_EN_BIT  = 4;
    localparam int WD_FLAG_BIT    = 2;
    localparam int WD_RUN_BIT     = 1;

    // Timing
    localparam int CLK_KHZ          = 125000;
    localparam int WD_UNIT_SHORT_MS = 150;
    localparam int WD_UNIT_LONG_MS  = 2500;
    localparam int WD_SHORT_CYC     = WD_UNIT_SHORT_MS * CLK_KHZ;
    localparam int WD_LONG_CYC      = WD_UNIT_LONG_MS * CLK_KHZ;
    localparam int RST_PULSE_CYC    = 16;

    typedef enum logic [1:0] {CSC_IDLE, CSC_CMD, CSC_DATA} csc_state_e;
endpackage
`default_nettype wire

// ==== csc_wdog_tick.sv ====
// Watchdog prescaler that emits one pulse per count unit
`default_nettype none
module csc_wdog_tick #(
    parameter int SHORT_CYC = csc_pkg::WD_SHORT_CYC,
    parameter int LONG_CYC  = csc_pkg::WD_LONG_CYC
) (
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic enable,
    input  wire logic restart,
    input  wire logic long_scale,
    output logic      tick
);
    logic [31:0] div_ff;
    logic [31:0] nxt_div;
    logic        tick_ff;
    logic        nxt_tick;
    logic [31:0] limit;

    assign tick = tick_ff;

    ////////////////////////////////////////////////////////////////////////
    // Divider; restart realigns the unit so the first one is a full unit
    always_comb
    begin
        limit    = long_scale ? LONG_CYC - 1 : SHORT_CYC - 1;
        nxt_div  = div_ff;
        nxt_tick = 1'b0;
        if (restart || !enable)
        begin
            nxt_div = 32'h0000_0000;
        end
        else if (div_ff >= limit)
        begin
            nxt_div  = 32'h0000_0000;
            nxt_tick = 1'b1;
        end
        else
        begin
            nxt_div = div_ff + 32'h0000_0001;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            div_ff  <= 32'h0000_0000;
            tick_ff <= 1'b0;
        end
        else
        begin
            div_ff  <= nxt_div;
            tick_ff <= nxt_tick;
        end
    end
endmodule
`default_nettype wire
